//--- hw/retry_pkg.sv
package retry_pkg;
   // register byte offsets (wishbone, one word each)
   localparam logic [7:0] ADDR_FAULT_SEL = 8'h00;
   localparam logic [7:0] ADDR_COUNT_LIMIT = 8'h04;
   localparam logic [7:0] ADDR_WAIT_TIME = 8'h08;
   localparam logic [7:0] ADDR_SUCCESS_CNT = 8'h0c;
   localparam logic [7:0] ADDR_CONFIG = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // reset values
   localparam logic [7:0] FAULT_SEL_RST = 8'h00;
   localparam logic [7:0] COUNT_LIMIT_RST = 8'h00;
   localparam logic [15:0] WAIT_TIME_RST = 16'h000a;
   localparam logic [15:0] COAST_RST = 16'h270f;
   localparam logic [7:0] DISPLAY_RST = 8'h00;
   localparam logic [7:0] TERM_FUNC_RST = 8'h00;
   // setting limits
   localparam logic [7:0] FAULT_SEL_MAX = 8'h05;
   localparam logic [7:0] COUNT_PLAIN_MAX = 8'h0a;
   localparam logic [7:0] COUNT_ALARM_MIN = 8'h65;
   localparam logic [7:0] COUNT_ALARM_MAX = 8'h6e;
   localparam logic [7:0] COUNT_ALARM_BASE = 8'h64;
   localparam logic [15:0] WAIT_TIME_MAX = 16'h1770;
   localparam logic [15:0] COAST_DISABLED = 16'h270f;
   localparam logic [7:0] TERM_POS_CODE = 8'h40;
   localparam logic [7:0] TERM_NEG_CODE = 8'ha4;
   // config register fields
   localparam int CFG_COAST_LSB = 0;
   localparam int CFG_DISPLAY_LSB = 16;
   // status register fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_FAILS_LSB = 4;
   localparam int ST_EXCESS_BIT = 8;
   localparam int ST_FIRST_LSB = 16;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int SUCCESS_MULT = 4;
   // fault vector positions
   localparam int N_FAULTS = 16;
   localparam int F_OC_ACC = 0;
   localparam int F_OC_CONST = 1;
   localparam int F_OC_DEC = 2;
   localparam int F_OV_ACC = 3;
   localparam int F_OV_CONST = 4;
   localparam int F_OV_DEC = 5;
   localparam int F_MOTOR_OL = 6;
   localparam int F_DRIVE_OL = 7;
   localparam int F_BRAKE = 8;
   localparam int F_EARTH = 9;
   localparam int F_EXT_THERM = 10;
   localparam int F_THERMISTOR = 11;
   localparam int F_STALL = 12;
   localparam int F_STORAGE = 13;
   localparam int F_IN_PHASE = 14;
   localparam int F_CUR_DET = 15;
   // retryable masks per selection
   localparam logic [15:0] MASK_SEL0 = 16'hffff;
   localparam logic [15:0] MASK_SEL1 = 16'h0007;
   localparam logic [15:0] MASK_SEL2 = 16'h0038;
   localparam logic [15:0] MASK_SEL3 = 16'h003f;
   localparam logic [15:0] MASK_SEL4 = 16'hf33f;
   localparam logic [15:0] MASK_SEL5 = 16'h0005;
   localparam logic [4:0] NO_FAULT_CODE = 5'h1f;

   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_WAIT = 3'b001,
      ST_RESTART = 3'b010,
      ST_PROVE = 3'b011,
      ST_LATCHED = 3'b100
   } state_t;
endpackage : retry_pkg

//--- hw/fault_retry_sequencer.sv
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fault_retry_sequencer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [retry_pkg::N_FAULTS-1:0] fault_i,
   input wire logic power_on_phase_i,
   input wire logic ext_reset_i,
   output logic fault_reset_o,
   output logic restart_o,
   output logic restart_power_fail_timing_o,
   output logic keep_thermal_data_o,
   output logic trip_o,
   output logic alarm_o,
   output logic retry_excess_fault_o,
   output logic retry_in_progress_out_o,
   output logic [4:0] first_fault_code_o
);
   import retry_pkg::*;

   logic [7:0] retry_fault_class_select;
   logic [7:0] retry_count_limit;
   logic [15:0] retry_wait_time;
   logic [15:0] retry_success_counter;
   logic [15:0] restart_coasting_setting;
   logic [7:0] extended_param_display;
   logic [7:0] output_terminal_func_a;
   state_t state;
   logic [3:0] fail_count;
   logic [4:0] first_fault;
   logic storage_at_power_on;
   logic [31:0] tick_div;
   logic [17:0] tick_count;
   logic [17:0] target_ticks;
   logic tick;
   logic [15:0] fault_mask;
   logic [3:0] allowed;
   logic alarm_during_retry;
   logic any_fault;
   logic retryable;
   logic wr;
   logic [4:0] code_of;

   function automatic logic [4:0] first_code(input logic [N_FAULTS-1:0] f);
      logic [4:0] c;
      c = NO_FAULT_CODE;
      for (int i = N_FAULTS - 1; i >= 0; i--) begin
         if (f[i]) begin
            c = 5'(i);
         end
      end
      return c;
   endfunction : first_code

   always_comb begin
      unique case (retry_fault_class_select)
         8'h00: fault_mask = MASK_SEL0;
         8'h01: fault_mask = MASK_SEL1;
         8'h02: fault_mask = MASK_SEL2;
         8'h03: fault_mask = MASK_SEL3;
         8'h04: fault_mask = MASK_SEL4;
         8'h05: fault_mask = MASK_SEL5;
         default: fault_mask = 16'h0000;
      endcase
   end

   always_comb begin
      if (retry_count_limit >= COUNT_ALARM_MIN && retry_count_limit <= COUNT_ALARM_MAX) begin
         allowed = 4'(retry_count_limit - COUNT_ALARM_BASE);
         alarm_during_retry = 1'b1;
      end else if (retry_count_limit <= COUNT_PLAIN_MAX) begin
         allowed = 4'(retry_count_limit);
         alarm_during_retry = 1'b0;
      end else begin
         allowed = 4'h0;
         alarm_during_retry = 1'b0;
      end
   end

   // storage fault seen at power-on is never retried; live phase covers the first trip edge
   assign retryable = |(fault_i & fault_mask) &&
      !(fault_i[F_STORAGE] && (storage_at_power_on || power_on_phase_i));
   assign any_fault = |fault_i;
   assign code_of = first_code(fault_i);
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && (&wb_sel_i);
   // zero wait still waits one tick; proving window is four waits plus one tick
   assign target_ticks = (retry_wait_time == 16'h0000) ? 18'h00001 : 18'(retry_wait_time);
   assign tick = (tick_div == 32'(TICK_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         storage_at_power_on <= 1'b0;
      end else if (power_on_phase_i && fault_i[F_STORAGE]) begin
         storage_at_power_on <= 1'b1;
      end
   end

   // tick generator, cleared while nothing is being timed
   always_ff @(posedge clk_i) begin
      if (rst_i || state == ST_RUN || state == ST_LATCHED || tick) begin
         tick_div <= 32'h0;
      end else begin
         tick_div <= tick_div + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_RUN;
         tick_count <= 18'h0;
         fail_count <= 4'h0;
         first_fault <= NO_FAULT_CODE;
         retry_excess_fault_o <= 1'b0;
      end else begin
         unique case (state)
            ST_RUN: begin
               tick_count <= 18'h0;
               if (any_fault) begin
                  first_fault <= code_of;
                  if (retryable && allowed != 4'h0) begin
                     state <= ST_WAIT;
                  end else begin
                     state <= ST_LATCHED;
                  end
               end
            end
            ST_WAIT: begin
               if (tick) begin
                  tick_count <= tick_count + 18'h1;
               end
               if (tick && tick_count + 18'h1 >= target_ticks) begin
                  state <= ST_RESTART;
                  tick_count <= 18'h0;
               end
            end
            ST_RESTART: begin
               state <= ST_PROVE;
            end
            ST_PROVE: begin
               if (any_fault) begin
                  tick_count <= 18'h0;
                  if (fail_count + 4'h1 > allowed || !retryable) begin
                     retry_excess_fault_o <= (fail_count + 4'h1 > allowed);
                     state <= ST_LATCHED;
                  end else begin
                     fail_count <= fail_count + 4'h1;
                     state <= ST_WAIT;
                  end
               end else begin
                  if (tick) begin
                     tick_count <= tick_count + 18'h1;
                  end
                  if (tick && tick_count >= 18'(SUCCESS_MULT) * target_ticks) begin
                     fail_count <= 4'h0;
                     first_fault <= NO_FAULT_CODE;
                     state <= ST_RUN;
                  end
               end
            end
            ST_LATCHED: begin
               if (ext_reset_i) begin
                  state <= ST_RUN;
                  fail_count <= 4'h0;
                  first_fault <= NO_FAULT_CODE;
                  retry_excess_fault_o <= 1'b0;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   // restart pulse and side info for restart control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_reset_o <= 1'b0;
         restart_o <= 1'b0;
         restart_power_fail_timing_o <= 1'b0;
         keep_thermal_data_o <= 1'b0;
      end else begin
         fault_reset_o <= (state == ST_WAIT && tick && tick_count + 18'h1 >= target_ticks);
         restart_o <= (state == ST_RESTART);
         restart_power_fail_timing_o <= (restart_coasting_setting != COAST_DISABLED);
         keep_thermal_data_o <= (state == ST_WAIT || state == ST_RESTART);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trip_o <= 1'b0;
         alarm_o <= 1'b0;
         retry_in_progress_out_o <= 1'b0;
         first_fault_code_o <= NO_FAULT_CODE;
      end else begin
         trip_o <= (state == ST_LATCHED || state == ST_WAIT);
         if (state == ST_LATCHED) begin
            alarm_o <= 1'b1;
         end else if (state == ST_WAIT || state == ST_RESTART) begin
            alarm_o <= alarm_during_retry;
         end else begin
            alarm_o <= 1'b0;
         end
         // terminal polarity from assigned function code
         if (output_terminal_func_a == TERM_NEG_CODE) begin
            retry_in_progress_out_o <= !(state == ST_WAIT || state == ST_RESTART);
         end else if (output_terminal_func_a == TERM_POS_CODE) begin
            retry_in_progress_out_o <= (state == ST_WAIT || state == ST_RESTART);
         end else begin
            retry_in_progress_out_o <= 1'b0;
         end
         first_fault_code_o <= first_fault;
      end
   end

   // parameter registers, all but the config register locked unless display setting is 0
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         retry_fault_class_select <= FAULT_SEL_RST;
         retry_count_limit <= COUNT_LIMIT_RST;
         retry_wait_time <= WAIT_TIME_RST;
         restart_coasting_setting <= COAST_RST;
         extended_param_display <= DISPLAY_RST;
         output_terminal_func_a <= TERM_FUNC_RST;
      end else if (wr) begin
         if (wb_adr_i == ADDR_CONFIG) begin
            restart_coasting_setting <= wb_dat_i[CFG_COAST_LSB +: 16];
            extended_param_display <= wb_dat_i[CFG_DISPLAY_LSB +: 8];
            output_terminal_func_a <= wb_dat_i[CFG_DISPLAY_LSB + 8 +: 8];
         end else if (extended_param_display == 8'h00) begin
            if (wb_adr_i == ADDR_FAULT_SEL && wb_dat_i[7:0] <= FAULT_SEL_MAX) begin
               retry_fault_class_select <= wb_dat_i[7:0];
            end
            if (wb_adr_i == ADDR_COUNT_LIMIT && (wb_dat_i[7:0] <= COUNT_PLAIN_MAX ||
                (wb_dat_i[7:0] >= COUNT_ALARM_MIN && wb_dat_i[7:0] <= COUNT_ALARM_MAX))) begin
               retry_count_limit <= wb_dat_i[7:0];
            end
            if (wb_adr_i == ADDR_WAIT_TIME && wb_dat_i[15:0] <= WAIT_TIME_MAX) begin
               retry_wait_time <= wb_dat_i[15:0];
            end
         end
      end
   end

   // success increment wins over a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         retry_success_counter <= 16'h0;
      end else if (state == ST_PROVE && !any_fault && tick &&
                   tick_count >= 18'(SUCCESS_MULT) * target_ticks) begin
         retry_success_counter <= retry_success_counter + 16'h1;
      end else if (wr && wb_adr_i == ADDR_SUCCESS_CNT && extended_param_display == 8'h00 &&
                   wb_dat_i[15:0] == 16'h0000) begin
         retry_success_counter <= 16'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         unique case (wb_adr_i)
            ADDR_FAULT_SEL: wb_dat_o <= {24'h0, retry_fault_class_select};
            ADDR_COUNT_LIMIT: wb_dat_o <= {24'h0, retry_count_limit};
            ADDR_WAIT_TIME: wb_dat_o <= {16'h0, retry_wait_time};
            ADDR_SUCCESS_CNT: wb_dat_o <= {16'h0, retry_success_counter};
            ADDR_CONFIG: wb_dat_o <= {output_terminal_func_a, extended_param_display,
                                      restart_coasting_setting};
            ADDR_STATUS: wb_dat_o <= {11'h0, first_fault, 7'h0, retry_excess_fault_o,
                                      fail_count, 1'b0, state};
            default: wb_dat_o <= 32'h0;
         endcase
      end
   end
endmodule : fault_retry_sequencer
`default_nettype wire

//--- tb/fault_source.sv
`timescale 1ns/1ps
`default_nettype none
module fault_source (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic fire_i,
   input wire logic [3:0] idx_i,
   input wire logic fault_reset_i,
   output logic [15:0] fault_o
);
   logic [1:0] hold;
   // a detector level stands three cycles, and drops early on the clearing pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || fault_reset_i || (hold == 2'h0 && !fire_i)) begin
         fault_o <= 16'h0000;
         hold <= 2'h0;
      end else if (fire_i) begin
         fault_o <= 16'h0001 << idx_i;
         hold <= 2'h2;
      end else begin
         hold <= hold - 2'h1;
      end
   end
endmodule : fault_source
`default_nettype wire

//--- tb/fault_retry_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fault_retry_sequencer_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [retry_pkg::N_FAULTS-1:0] fault_i,
   input wire logic ext_reset_i,
   input wire logic fault_reset_o,
   input wire logic restart_o,
   input wire logic trip_o,
   input wire logic alarm_o,
   input wire logic retry_excess_fault_o,
   input wire logic [4:0] first_fault_code_o
);
   logic any_fault;
   assign any_fault = |fault_i;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_restart;
      restart_o ##1 !restart_o;
   endsequence
   property p_ack_resp; s_req |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i == 8'h18 |-> wb_dat_o == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_trip_cause; $rose(trip_o) |-> $past(any_fault, 2); endproperty
   a_trip_cause: assert property (p_trip_cause) else $error("trip without fault");
   property p_excess; retry_excess_fault_o |=> trip_o && alarm_o; endproperty
   a_excess: assert property (p_excess) else $error("excess fault without trip");
   property p_first_keep; trip_o [*3] |-> $stable(first_fault_code_o); endproperty
   a_first_keep: assert property (p_first_keep) else $error("first fault overwritten");
   property p_restart; fault_reset_o |=> s_restart; endproperty
   a_restart: assert property (p_restart) else $error("restart not after clear");
   property p_release; $fell(trip_o) |-> $past(ext_reset_i) || fault_reset_o || $past(fault_reset_o); endproperty
   a_release: assert property (p_release) else $error("trip dropped unprompted");
endmodule : fault_retry_sequencer_assertions
bind fault_retry_sequencer fault_retry_sequencer_assertions i_chk (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .fault_i, .ext_reset_i, .fault_reset_o,
   .restart_o, .trip_o, .alarm_o, .retry_excess_fault_o, .first_fault_code_o);
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import retry_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pwr_on = 1'b0, xrst = 1'b0, fire = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [3:0] sel = 4'h0, fidx = 4'h0;
   logic [15:0] flt;
   logic frst, rstart, pft, keep, trip, alarm, excess, rip;
   logic [4:0] first;
   logic [15:0] masks [6] = '{16'hffff, 16'h0007, 16'h0038, 16'h003f, 16'hf33f, 16'h0005};
   int fails = 0, samples_checked = 0, m_sel, m_lim, m_wait, lim, rt;
   logic [31:0] m_cfg;
   logic [7:0] tc;
   fault_retry_sequencer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
      .wb_ack_o(ack), .fault_i(flt), .power_on_phase_i(pwr_on), .ext_reset_i(xrst),
      .fault_reset_o(frst), .restart_o(rstart), .restart_power_fail_timing_o(pft),
      .keep_thermal_data_o(keep), .trip_o(trip), .alarm_o(alarm), .retry_excess_fault_o(excess),
      .retry_in_progress_out_o(rip), .first_fault_code_o(first));
   fault_source i_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .idx_i(fidx),
      .fault_reset_i(frst), .fault_o(flt));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      q = rdat;
      if (n == 20) fails++;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      bus(1'b1, a, d, s);
      if (s != 4'hf) return;
      if (a == ADDR_CONFIG) m_cfg = d;
      else if (m_cfg[23:16] != 8'h00) return;
      else if (a == ADDR_FAULT_SEL && d <= 5) m_sel = d;
      else if (a == ADDR_COUNT_LIMIT && (d <= 10 || (d >= 101 && d <= 110))) m_lim = d;
      else if (a == ADDR_WAIT_TIME && d <= 6000) m_wait = d;
   endtask : reg_wr
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      check(q, e);
   endtask : reg_chk
   task automatic do_reset(input int n);
      rst_i <= 1'b1;
      repeat (n) @(posedge clk_i);
      rst_i <= 1'b0;
      m_sel = 0;
      m_lim = 0;
      m_wait = 10;
      m_cfg = 32'h0000270f;
      @(posedge clk_i);
   endtask : do_reset
   task automatic fire_fault(input int f);
      fire <= 1'b1;
      fidx <= 4'(f);
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : fire_fault
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      #1000000;
      fails++;
      $display("Error %0t watchdog expired", $time);
      print_verdict();
   end
   initial begin
      void'($urandom(41));
      do_reset(12);
      reg_chk(ADDR_WAIT_TIME, 32'h0000000a);
      reg_chk(ADDR_STATUS, 32'h001f0000);
      reg_wr(ADDR_FAULT_SEL, 32'h6, 4'hf);
      reg_wr(ADDR_COUNT_LIMIT, 32'h64, 4'hf);
      reg_wr(ADDR_COUNT_LIMIT, 32'h0b, 4'hf);
      reg_wr(ADDR_WAIT_TIME, 32'h1771, 4'hf);
      reg_wr(ADDR_WAIT_TIME, 32'h1770, 4'hf);
      reg_wr(ADDR_FAULT_SEL, $urandom_range(5), 4'h3);
      reg_wr(ADDR_CONFIG, 32'h00010005, 4'hf);
      reg_wr(ADDR_FAULT_SEL, 32'h2, 4'hf);
      check(32'(pft), 32'h1);
      reg_wr(ADDR_CONFIG, 32'h0000270f, 4'hf);
      check(32'(pft), 32'h0);
      reg_wr(ADDR_SUCCESS_CNT, 32'h0, 4'hf);
      reg_chk(ADDR_FAULT_SEL, m_sel);
      reg_chk(ADDR_COUNT_LIMIT, m_lim);
      reg_chk(ADDR_WAIT_TIME, m_wait);
      reg_chk(ADDR_SUCCESS_CNT, 32'h0);
      reg_chk(8'h18, 32'h0);
      for (int s = 0; s < 6; s++) begin
         for (int f = 0; f < 16; f++) begin
            lim = ((f + s) % 3 == 0) ? 0 : ((f + s) % 3 == 1) ? 1 + $urandom_range(9) : 101 + $urandom_range(9);
            tc = (s % 3 == 0) ? 8'h40 : ((s % 3 == 1) ? 8'ha4 : 8'h00);
            do_reset(2);
            pwr_on <= (s == 0 && f == 13);
            reg_wr(ADDR_CONFIG, {tc, 24'h00270f}, 4'hf);
            reg_wr(ADDR_FAULT_SEL, s, 4'hf);
            reg_wr(ADDR_COUNT_LIMIT, lim, 4'hf);
            reg_wr(ADDR_WAIT_TIME, 32'h0, 4'hf);
            rt = (masks[s][f] && lim != 0 && !(s == 0 && f == 13)) ? 1 : 0;
            fire_fault(f);
            check(32'(trip), 32'h1);
            check(32'(keep), rt);
            check(32'(alarm), (rt == 0 || lim > 100) ? 1 : 0);
            check(32'(rip), (tc == 8'h40) ? rt : ((tc == 8'ha4) ? 1 - rt : 0));
            bus(1'b0, ADDR_STATUS, 32'h0, 4'hf);
            check({29'h0, q[2:0]}, rt ? 1 : 4);
            fire_fault((f + 1) % 16);
            check(32'(first), f);
            if (rt == 0) begin
               xrst <= 1'b1;
               repeat (2) @(posedge clk_i);
               xrst <= 1'b0;
               repeat (2) @(posedge clk_i);
               check(32'(trip), 32'h0);
            end
         end
      end
      print_verdict();
   end
endmodule : tb
`default_nettype wire
